// ---- src/rtcv_pkg.sv ----
`default_nettype none
package rtcv_pkg;
    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HALF_SEC_MS = 500;
    localparam int unsigned HALF_SEC_CYCLES_DEF = CLK_HZ / 1000 * HALF_SEC_MS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALARM_CTRL = 8'h04;
    localparam logic [7:0] OFS_TIME_WIN = 8'h08;
    localparam logic [7:0] OFS_ALARM_WIN = 8'h0c;

    // control field positions
    localparam int unsigned CTRL_COUNT_EN_BIT = 15;
    localparam int unsigned CTRL_WREN_BIT = 13;
    localparam int unsigned CTRL_HALF_BIT = 11;
    localparam int unsigned PTR_LSB = 8;

    // control reset values
    localparam logic CTRL_COUNT_EN_RST = 1'b0;
    localparam logic CTRL_WREN_RST = 1'b0;
    localparam logic CTRL_HALF_RST = 1'b0;
    localparam logic [1:0] PTR_RST = 2'h0;

    // window pointer selections
    localparam logic [1:0] SEL_MIN_SEC = 2'h0;
    localparam logic [1:0] SEL_WDHR = 2'h1;
    localparam logic [1:0] SEL_MDAY = 2'h2;
    localparam logic [1:0] SEL_YEAR = 2'h3;

    // implemented bits of each value register
    localparam logic [15:0] MASK_YEAR = 16'h00ff;
    localparam logic [15:0] MASK_MDAY = 16'h1f3f;
    localparam logic [15:0] MASK_WDHR = 16'h073f;
    localparam logic [15:0] MASK_MIN_SEC = 16'h7f7f;

    // bcd ranges
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] BCD_SEC_MAX = 8'h59;
    localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
    localparam logic [7:0] BCD_WEEKDAY_DIGIT_MAX = 8'h06;
    localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
    localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0] BCD_FEB = 8'h02;
    localparam logic [7:0] BCD_DAY_28 = 8'h28;
    localparam logic [7:0] BCD_DAY_29 = 8'h29;
    localparam logic [7:0] BCD_DAY_30 = 8'h30;
    localparam logic [7:0] BCD_DAY_31 = 8'h31;
endpackage : rtcv_pkg
`default_nettype wire

// ---- src/rtcv_bcd_step.sv ----
`default_nettype none
module rtcv_bcd_step (
    // current two-digit value and range
    input wire logic [7:0] val_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] hi_i,
    input wire logic inc_i,
    // stepped value
    output logic [7:0] nxt_o,
    output logic wrap_o
);
    always_comb begin
        nxt_o = val_i;
        wrap_o = 1'b0;
        if (inc_i) begin
            // out-of-range values still step; they reach a wrap once in range
            if (val_i == hi_i) begin
                nxt_o = lo_i;
                wrap_o = 1'b1;
            end else if (val_i[3:0] >= 4'h9) begin
                nxt_o = {val_i[7:4] + 4'h1, 4'h0};
            end else begin
                nxt_o = {val_i[7:4], val_i[3:0] + 4'h1};
            end
        end
    end
endmodule : rtcv_bcd_step
`default_nettype wire

// ---- src/rtcv_value_regs.sv ----
// Contract
// [RL1] year holds tens digit in bits 7-4, ones digit in bits 3-0, bcd
// [RL2] unimplemented value bits read zero, whole year upper byte included
// [RL3] year write accepted only while value_write_enable is 1
// [RL4] month tens bit at 12, month ones digit bits 11-8, bcd
// [RL5] day tens digit bits 5-4, day ones digit bits 3-0, bcd
// [RL6] month-day and weekday-hour writes, time and alarm, need value_write_enable
// [RL7] weekday digit sits in bits 10-8, values 0 to 6
// [RL8] hour tens digit bits 5-4, hour ones digit bits 3-0, bcd
// [RL9] minute tens digit bits 14-12, minute ones digit bits 11-8, bcd
// [RL10] second tens bits 6-4, ones bits 3-0; bit 7 unimplemented
// [RL11] alarm set mirrors month-day, weekday-hour, minute-second; no alarm year
// [RL12] digit fields are not touched by reset
// [RL13] enabled time counts in bcd, carries seconds up through year
// [RL14] time pointer decrements per upper-byte access until 00
// [RL15] alarm pointer decrements per upper-byte access until 00
// [RL16] value_write_enable at control bit 13 locks time window writes
// [RL17] write to seconds byte clears half_second_status; here a half tick in the same cycle toggles it instead
`default_nettype none
module rtcv_value_regs #(
    parameter int unsigned HALF_SEC_CYCLES = rtcv_pkg::HALF_SEC_CYCLES_DEF,
    parameter int unsigned TICK_W = 23
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // clock unit side
    output logic value_write_enable_o,
    output logic [1:0] time_window_pointer_o,
    output logic [1:0] alarm_window_pointer_o,
    output logic half_second_status_o
);
    import rtcv_pkg::*;

    if (HALF_SEC_CYCLES < 2 || HALF_SEC_CYCLES > (2 ** TICK_W)) begin : g_chk
        $error("half second count does not fit the tick counter");
    end

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic wren;
        logic cnt_en;
        logic half;
        logic [1:0] tptr;
        logic [1:0] aptr;
        logic [TICK_W-1:0] tick;
        logic [15:0] year;
        logic [15:0] mday;
        logic [15:0] wdhr;
        logic [15:0] min_sec;
        logic [15:0] amday;
        logic [15:0] awdhr;
        logic [15:0] aminsec;
    } rtcv_state_s;

    rtcv_state_s st_ff;
    rtcv_state_s nxt_st;

    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic hit_twin;
    logic hit_awin;
    logic half_tick;
    logic sec_inc;
    logic [7:0] sec_n;
    logic [7:0] min_n;
    logic [7:0] hr_n;
    logic [7:0] wd_n;
    logic [7:0] dy_n;
    logic [7:0] mo_n;
    logic [7:0] yr_n;
    logic sec_w;
    logic min_w;
    logic hr_w;
    logic dy_w;
    logic mo_w;
    logic leap;
    logic [7:0] day_max;
    logic [15:0] time_rd;
    logic [15:0] alarm_rd;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] m;
        m[15:8] = sel[1] ? d[15:8] : old[15:8];
        m[7:0] = sel[0] ? d[7:0] : old[7:0];
        return m & mask;
    endfunction : merge16

    // a new request is taken only when no answer is pending
    assign req = cyc_i & stb_i;
    assign acc = req & ~st_ff.ack;
    assign wr = acc & we_i;
    assign rd = acc & ~we_i;
    assign hit_twin = adr_i == OFS_TIME_WIN;
    assign hit_awin = adr_i == OFS_ALARM_WIN;
    assign half_tick = st_ff.cnt_en & (st_ff.tick == TICK_W'(HALF_SEC_CYCLES - 1));
    assign sec_inc = half_tick & st_ff.half;

    // leap year when the bcd year is a multiple of four
    assign leap = st_ff.year[4] ? (st_ff.year[3:0] == 4'h2 || st_ff.year[3:0] == 4'h6)
                                : (st_ff.year[3:0] == 4'h0 || st_ff.year[3:0] == 4'h4 ||
                                   st_ff.year[3:0] == 4'h8);

    always_comb begin
        case ({3'h0, st_ff.mday[12:8]})
            BCD_FEB: day_max = leap ? BCD_DAY_29 : BCD_DAY_28;
            8'h04, 8'h06, 8'h09, 8'h11: day_max = BCD_DAY_30;
            default: day_max = BCD_DAY_31;
        endcase
    end

    // [RL13] bcd carry chain
    rtcv_bcd_step u_sec (
        .val_i({1'b0, st_ff.min_sec[6:0]}),
        .lo_i(BCD_ZERO),
        .hi_i(BCD_SEC_MAX),
        .inc_i(sec_inc),
        .nxt_o(sec_n),
        .wrap_o(sec_w)
    );
    rtcv_bcd_step u_min (
        .val_i({1'b0, st_ff.min_sec[14:8]}),
        .lo_i(BCD_ZERO),
        .hi_i(BCD_SEC_MAX),
        .inc_i(sec_w),
        .nxt_o(min_n),
        .wrap_o(min_w)
    );
    rtcv_bcd_step u_hour (
        .val_i({2'h0, st_ff.wdhr[5:0]}),
        .lo_i(BCD_ZERO),
        .hi_i(BCD_HOUR_MAX),
        .inc_i(min_w),
        .nxt_o(hr_n),
        .wrap_o(hr_w)
    );
    rtcv_bcd_step u_wkday (
        .val_i({5'h0, st_ff.wdhr[10:8]}),
        .lo_i(BCD_ZERO),
        .hi_i(BCD_WEEKDAY_DIGIT_MAX),
        .inc_i(hr_w),
        .nxt_o(wd_n),
        .wrap_o()
    );
    rtcv_bcd_step u_day (
        .val_i({2'h0, st_ff.mday[5:0]}),
        .lo_i(BCD_ONE),
        .hi_i(day_max),
        .inc_i(hr_w),
        .nxt_o(dy_n),
        .wrap_o(dy_w)
    );
    rtcv_bcd_step u_month (
        .val_i({3'h0, st_ff.mday[12:8]}),
        .lo_i(BCD_ONE),
        .hi_i(BCD_MONTH_MAX),
        .inc_i(dy_w),
        .nxt_o(mo_n),
        .wrap_o(mo_w)
    );
    rtcv_bcd_step u_year (
        .val_i(st_ff.year[7:0]),
        .lo_i(BCD_ZERO),
        .hi_i(BCD_YEAR_MAX),
        .inc_i(mo_w),
        .nxt_o(yr_n),
        .wrap_o()
    );

    // [RL1] [RL2] [RL4] [RL5] [RL7] [RL8] [RL9] [RL10] field masks on reads
    always_comb begin
        case (st_ff.tptr)
            SEL_MIN_SEC: time_rd = st_ff.min_sec & MASK_MIN_SEC;
            SEL_WDHR: time_rd = st_ff.wdhr & MASK_WDHR;
            SEL_MDAY: time_rd = st_ff.mday & MASK_MDAY;
            default: time_rd = st_ff.year & MASK_YEAR;
        endcase
        // [RL11] alarm pointer 11 has nothing behind it
        case (st_ff.aptr)
            SEL_MIN_SEC: alarm_rd = st_ff.aminsec & MASK_MIN_SEC;
            SEL_WDHR: alarm_rd = st_ff.awdhr & MASK_WDHR;
            SEL_MDAY: alarm_rd = st_ff.amday & MASK_MDAY;
            default: alarm_rd = 16'h0000;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = acc;
        nxt_st.rdat = 32'h0000_0000;
        nxt_st.tick = '0;
        if (st_ff.cnt_en && !half_tick) begin
            nxt_st.tick = st_ff.tick + TICK_W'(1);
        end
        // [RL13] digits advance once per second
        if (sec_inc) begin
            nxt_st.min_sec = {1'b0, min_n[6:0], 1'b0, sec_n[6:0]};
            nxt_st.wdhr = {5'h00, wd_n[2:0], 2'h0, hr_n[5:0]};
            nxt_st.mday = {3'h0, mo_n[4:0], 2'h0, dy_n[5:0]};
            nxt_st.year = {8'h00, yr_n};
        end
        if (rd) begin
            case (adr_i)
                OFS_CTRL: begin
                    // [RL16] write enable visible at bit 13
                    nxt_st.rdat[CTRL_COUNT_EN_BIT] = st_ff.cnt_en;
                    nxt_st.rdat[CTRL_WREN_BIT] = st_ff.wren;
                    nxt_st.rdat[CTRL_HALF_BIT] = st_ff.half;
                    nxt_st.rdat[PTR_LSB+:2] = st_ff.tptr;
                end
                OFS_ALARM_CTRL: nxt_st.rdat[PTR_LSB+:2] = st_ff.aptr;
                OFS_TIME_WIN: nxt_st.rdat[15:0] = time_rd;
                OFS_ALARM_WIN: nxt_st.rdat[15:0] = alarm_rd;
                default: nxt_st.rdat = 32'h0000_0000;
            endcase
        end
        if (wr && sel_i[1]) begin
            case (adr_i)
                OFS_CTRL: begin
                    nxt_st.wren = dat_i[CTRL_WREN_BIT];
                    nxt_st.tptr = dat_i[PTR_LSB+:2];
                    // counting is only switched while writes are unlocked
                    if (st_ff.wren) begin
                        nxt_st.cnt_en = dat_i[CTRL_COUNT_EN_BIT];
                    end
                end
                OFS_ALARM_CTRL: nxt_st.aptr = dat_i[PTR_LSB+:2];
                default: nxt_st.aptr = st_ff.aptr;
            endcase
        end
        // [RL3] [RL6] [RL16] writes land only while unlocked; write beats counting
        if (wr && hit_twin && st_ff.wren) begin
            case (st_ff.tptr)
                SEL_MIN_SEC: begin
                    nxt_st.min_sec = merge16(st_ff.min_sec, dat_i, sel_i, MASK_MIN_SEC);
                    // [RL17] seconds write clears the half-second phase
                    if (sel_i[0]) begin
                        nxt_st.half = 1'b0;
                        nxt_st.tick = '0;
                    end
                end
                SEL_WDHR: nxt_st.wdhr = merge16(st_ff.wdhr, dat_i, sel_i, MASK_WDHR);
                SEL_MDAY: nxt_st.mday = merge16(st_ff.mday, dat_i, sel_i, MASK_MDAY);
                default: nxt_st.year = merge16(st_ff.year, dat_i, sel_i, MASK_YEAR);
            endcase
        end
        // [RL6] [RL11] alarm set, same lock
        if (wr && hit_awin && st_ff.wren) begin
            case (st_ff.aptr)
                SEL_MIN_SEC: nxt_st.aminsec = merge16(st_ff.aminsec, dat_i, sel_i, MASK_MIN_SEC);
                SEL_WDHR: nxt_st.awdhr = merge16(st_ff.awdhr, dat_i, sel_i, MASK_WDHR);
                SEL_MDAY: nxt_st.amday = merge16(st_ff.amday, dat_i, sel_i, MASK_MDAY);
                default: nxt_st.aminsec = st_ff.aminsec;
            endcase
        end
        // [RL14] time pointer steps down, locked or not
        if (acc && hit_twin && sel_i[1] && st_ff.tptr != 2'h0) begin
            nxt_st.tptr = st_ff.tptr - 2'h1;
        end
        // [RL15] alarm pointer steps down
        if (acc && hit_awin && sel_i[1] && st_ff.aptr != 2'h0) begin
            nxt_st.aptr = st_ff.aptr - 2'h1;
        end
        // half-second toggle wins over a clear in the same cycle
        if (half_tick) begin
            nxt_st.half = ~st_ff.half;
        end
        // [RL12] reset leaves every digit field alone
        if (rst_i) begin
            nxt_st.ack = 1'b0;
            nxt_st.rdat = 32'h0000_0000;
            nxt_st.wren = CTRL_WREN_RST;
            nxt_st.cnt_en = CTRL_COUNT_EN_RST;
            nxt_st.half = CTRL_HALF_RST;
            nxt_st.tptr = PTR_RST;
            nxt_st.aptr = PTR_RST;
            nxt_st.tick = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    assign dat_o = st_ff.rdat;
    assign ack_o = st_ff.ack;
    assign value_write_enable_o = st_ff.wren;
    assign time_window_pointer_o = st_ff.tptr;
    assign alarm_window_pointer_o = st_ff.aptr;
    assign half_second_status_o = st_ff.half;

    // [RL1] year read upper byte zero
    a_year_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
        (rd && hit_twin && st_ff.tptr == SEL_YEAR) |=> (dat_o[31:8] == 24'h000000))
        else $error("year read shows upper bits");

    // [RL2] minute-second unimplemented bits
    a_min_sec_holes: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
        (rd && hit_twin && st_ff.tptr == SEL_MIN_SEC) |=> ((dat_o & 32'hffff_8080) == 32'h0))
        else $error("minute-second hole bits read nonzero");
    // [RL3] locked year write
    a_year_write_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
        (wr && hit_twin && st_ff.tptr == SEL_YEAR && !st_ff.wren && !st_ff.cnt_en)
        |=> $stable(st_ff.year))
        else $error("locked year write took effect");
    // [RL4] [RL5] month-day write lands
    a_mday_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4] [RL5]
        (wr && hit_twin && st_ff.tptr == SEL_MDAY && st_ff.wren && sel_i[1:0] == 2'h3)
        |=> ((st_ff.mday & MASK_MDAY) == ($past(dat_i[15:0]) & MASK_MDAY)))
        else $error("month-day write lost");
    // [RL6] locked alarm write
    a_alarm_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        (wr && hit_awin && st_ff.aptr == SEL_MDAY && !st_ff.wren) |=> $stable(st_ff.amday))
        else $error("locked alarm write took effect");
    // [RL7] [RL8] [RL11] alarm weekday-hour readback
    a_awdhr_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7] [RL8]
        (rd && hit_awin && st_ff.aptr == SEL_WDHR) |=> (dat_o[15:0] == (st_ff.awdhr & MASK_WDHR)))
        else $error("alarm weekday-hour read wrong");

    // [RL9] [RL10] last second of the hour rolls both fields
    a_sec_carry: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9] [RL10]
        (sec_inc && st_ff.min_sec[14:0] == 15'h5959 && !wr)
        |=> (st_ff.min_sec[14:0] == 15'h0000))
        else $error("second carry wrong");

    // [RL13] one second per two half ticks
    a_half_toggle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
        (half_tick && !(wr && hit_twin)) |=> (half_second_status_o != $past(half_second_status_o)))
        else $error("half-second phase did not toggle");

    // [RL14] time pointer decrement
    a_tptr_dec: assert property (@(posedge clk_i) disable iff (rst_i) // [RL14]
        (acc && hit_twin && sel_i[1] && st_ff.tptr != 2'h0)
        |=> (time_window_pointer_o == $past(st_ff.tptr) - 2'h1) ##1 !ack_o)
        else $error("time pointer did not step");

    // [RL15] alarm pointer parks at 00
    a_aptr_floor: assert property (@(posedge clk_i) disable iff (rst_i) // [RL15]
        (acc && hit_awin && st_ff.aptr == 2'h0) |=> (alarm_window_pointer_o == 2'h0))
        else $error("alarm pointer left 00");

    // [RL16] enable bit readback
    a_wren_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RL16]
        (rd && adr_i == OFS_CTRL) |=> (dat_o[13] == value_write_enable_o))
        else $error("write enable readback wrong");

    // [RL17] seconds write clears phase
    a_half_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RL17]
        (wr && hit_twin && st_ff.wren && st_ff.tptr == SEL_MIN_SEC && sel_i[0] && !half_tick)
        |=> !half_second_status_o)
        else $error("half-second phase not cleared");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");
endmodule : rtcv_value_regs
`default_nettype wire

// ---- verif/tb_rtcv_value_regs.sv ----
`default_nettype none
module tb_rtcv_value_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import rtcv_pkg::*;
    // short half second keeps the carry run brief
    localparam int unsigned HSC = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic value_write_enable_o;
    logic [1:0] time_window_pointer_o;
    logic [1:0] alarm_window_pointer_o;
    logic half_second_status_o;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] tw [4] = '{32'h0000_ff25, 32'h0000_f2f1, 32'h0000_fe23, 32'h0000_d9d9};
    logic [31:0] te [4] = '{32'h0000_0025, 32'h0000_1231, 32'h0000_0623, 32'h0000_5959};
    logic [31:0] cw [4] = '{32'h0000_0099, 32'h0000_1231, 32'h0000_0623, 32'h0000_5959};
    logic [31:0] ce [4] = '{32'h0000_0000, 32'h0000_0101, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] aw [4] = '{32'h0000_ffff, 32'h0000_0229, 32'h0000_0312, 32'h0000_3045};
    logic [31:0] ae [4] = '{32'h0000_0000, 32'h0000_0229, 32'h0000_0312, 32'h0000_3045};
    logic [1:0] pe [4] = '{2'h2, 2'h1, 2'h0, 2'h0};

    always #50 clk_i = ~clk_i;

    rtcv_value_regs #(
        .HALF_SEC_CYCLES(HSC),
        .TICK_W(23)
    ) dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .value_write_enable_o(value_write_enable_o),
        .time_window_pointer_o(time_window_pointer_o),
        .alarm_window_pointer_o(alarm_window_pointer_o),
        .half_second_status_o(half_second_status_o)
    );

    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_data

    task automatic chk_sig(input logic [1:0] got, input logic [1:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_sig

    // classic cycle: hold until ack sampled high, release at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: no ack", $time);
            close_out();
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, s, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        wb(1'b0, a, 4'h3, 32'h0000_0000, r);
        chk_data(r, exp, what);
    endtask : rd

    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask : settle

    // bounded wait for a half status level
    task automatic wait_half(input logic v);
        int n;
        n = 0;
        while (half_second_status_o !== v && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (half_second_status_o !== v) begin
            num_errors++;
            $display("CHECK FAILED at %0t: half status stuck", $time);
            close_out();
        end
    endtask : wait_half

    task automatic chk_idle_ports;
        chk_sig({1'b0, value_write_enable_o}, 2'h0, "enable after reset");
        chk_sig(time_window_pointer_o, 2'h0, "time ptr after reset");
        chk_sig(alarm_window_pointer_o, 2'h0, "alarm ptr after reset");
    endtask : chk_idle_ports

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk_idle_ports();
        chk_sig({1'b0, half_second_status_o}, 2'h0, "half after reset");
        rd(OFS_CTRL, 32'h0000_0000, "ctrl reset");
        wr(OFS_CTRL, 4'h3, 32'h0000_2300);
        settle();
        chk_sig({1'b0, value_write_enable_o}, 2'h1, "enable set");
        chk_sig(time_window_pointer_o, 2'h3, "time ptr load");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_TIME_WIN, 4'h3, tw[i]);
            settle();
            chk_sig(time_window_pointer_o, pe[i], "time ptr step");
        end
        wr(OFS_CTRL, 4'h3, 32'h0000_2300);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_TIME_WIN, te[i], "layout");
        end
        // locked writes: pointer walks but digits hold
        wr(OFS_CTRL, 4'h3, 32'h0000_0300);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_TIME_WIN, 4'h3, 32'h0000_0000);
        end
        settle();
        chk_sig(time_window_pointer_o, 2'h0, "locked ptr walk");
        wr(OFS_CTRL, 4'h3, 32'h0000_0300);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_TIME_WIN, te[i], "locked time write");
        end
        // count on, then clear half status by a seconds byte write
        wr(OFS_CTRL, 4'h3, 32'h0000_2000);
        wr(OFS_CTRL, 4'h3, 32'h0000_a000);
        wait_half(1'b1);
        // count enable, write enable and half status all visible while counting
        rd(OFS_CTRL, 32'h0000_a800, "ctrl while counting");
        wr(OFS_TIME_WIN, 4'h1, 32'h0000_0000);
        settle();
        chk_sig({1'b0, half_second_status_o}, 2'h0, "half cleared");
        // full carry from the last second of year 99
        wr(OFS_CTRL, 4'h3, 32'h0000_2300);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_TIME_WIN, 4'h3, cw[i]);
        end
        wr(OFS_CTRL, 4'h3, 32'h0000_a000);
        wait_half(1'b1);
        wait_half(1'b0);
        wr(OFS_CTRL, 4'h3, 32'h0000_2300);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_TIME_WIN, ce[i], "carry result");
        end
        // alarm set, pointer 11 has no register
        wr(OFS_ALARM_CTRL, 4'h3, 32'h0000_0300);
        settle();
        chk_sig(alarm_window_pointer_o, 2'h3, "alarm ptr load");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_ALARM_WIN, 4'h3, aw[i]);
            settle();
            chk_sig(alarm_window_pointer_o, pe[i], "alarm ptr step");
        end
        wr(OFS_ALARM_CTRL, 4'h3, 32'h0000_0300);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_ALARM_WIN, ae[i], "alarm layout");
        end
        wr(OFS_CTRL, 4'h3, 32'h0000_0000);
        wr(OFS_ALARM_CTRL, 4'h3, 32'h0000_0200);
        wr(OFS_ALARM_WIN, 4'h3, 32'h0000_0111);
        wr(OFS_ALARM_CTRL, 4'h3, 32'h0000_0200);
        rd(OFS_ALARM_WIN, 32'h0000_0229, "locked alarm write");
        // unmapped place reads zero, write ignored
        wr(8'h10, 4'hf, 32'hffff_ffff);
        rd(8'h10, 32'h0000_0000, "unmapped read");
        // second reset leaves digits alone
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk_idle_ports();
        wr(OFS_ALARM_CTRL, 4'h3, 32'h0000_0200);
        rd(OFS_ALARM_WIN, 32'h0000_0229, "digits kept over reset");
        close_out();
    end
endmodule : tb_rtcv_value_regs
`default_nettype wire
